// File: design/ebwe_pkg.sv
// ebwe_pkg: constants and carriers of the external bus wait extension.
// assumes one 125 MHz clock; all pins are synchronous to it.
// Function
// - wait low at first edge holds the access until wait returns high.
// - wait low later, standard wait states left, still extends the access.
// - split word read, late wait stretches both strobes, first half early.
// - half-word and byte reads always stretched correctly by wait.
// - late wait on write extends select, but write strobe rises on time.
package ebwe_pkg;
  localparam int unsigned WS_W       = 3;
  localparam int unsigned ADDR_W     = 24;
  localparam logic [1:0]  SIZE_BYTE  = 2'h0;
  localparam logic [1:0]  SIZE_HALF  = 2'h1;
  localparam logic [1:0]  SIZE_WORD  = 2'h2;
  localparam logic [WS_W-1:0] WS_RST = 3'h0;

  typedef struct packed {
    logic              write;
    logic [1:0]        size;
    logic [WS_W-1:0]   wait_states;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } ebwe_req_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_STD   = 4'h2,
    ST_HOLD  = 4'h4,
    ST_DONE  = 4'h8
  } ebwe_state_t;
endpackage : ebwe_pkg

// File: design/ebwe_top.sv
// ebwe_top: one external access with standard wait states and wait input.
// assumes requests arrive only while req_ready is high; the external party
// keeps its own programming constraints on minimum wait states.
`timescale 1ns/1ps
module ebwe_top (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // request side
  input  wire logic                          req_valid,
  input  wire ebwe_pkg::ebwe_req_t           req,
  output logic                               req_ready,
  output logic                               done,
  output logic [31:0]                        rdata,
  // external pins
  input  wire logic                          ext_wait_n,
  input  wire logic [15:0]                   data_in,
  output logic [15:0]                        data_out,
  output logic                               data_oe_n,
  output logic [ebwe_pkg::ADDR_W-1:0]        addr_out,
  output logic                               chip_select_n,
  output logic                               read_strobe_n,
  output logic                               write_strobe_n
);
  // =====================================================================
  // state
  // =====================================================================
  typedef struct packed {
    ebwe_pkg::ebwe_state_t      st;
    ebwe_pkg::ebwe_req_t        rq;
    logic                       second;
    logic                       late;
    logic                       ready;
    logic                       done;
    logic [31:0]                rdata;
    logic [15:0]                dout;
    logic                       oe_n;
    logic [ebwe_pkg::ADDR_W-1:0] addr;
    logic                       cs_n;
    logic                       rd_n;
    logic                       wr_n;
  } ebwe_regs_t;

  ebwe_regs_t r;
  ebwe_regs_t next_r;
  logic       ws_load;
  logic       ws_step;
  logic       ws_expired;

  function automatic logic is_split(input ebwe_pkg::ebwe_req_t q);
    is_split = !q.write && q.size == ebwe_pkg::SIZE_WORD;
  endfunction : is_split

  ebwe_wait_counter u_ws (
    .clk        (clk),
    .rst        (rst),
    .load       (ws_load),
    .load_value (next_r.rq.wait_states),
    .step       (ws_step),
    .expired    (ws_expired)
  );

  // =====================================================================
  // access sequencing
  // =====================================================================
  always_comb begin
    next_r  = r;
    ws_load = 1'b0;
    ws_step = 1'b0;
    next_r.done = 1'b0;
    unique case (r.st)
      ebwe_pkg::ST_IDLE: begin
        if (req_valid && r.ready) begin
          next_r.rq     = req;
          next_r.second = 1'b0;
          next_r.late   = 1'b0;
          next_r.ready  = 1'b0;
          next_r.addr   = req.addr;
          next_r.cs_n   = 1'b0;
          next_r.rd_n   = req.write;
          next_r.wr_n   = !req.write;
          next_r.oe_n   = !req.write;
          next_r.dout   = req.wdata[15:0];
          ws_load       = 1'b1;
          next_r.st     = ebwe_pkg::ST_STD;
        end
      end
      ebwe_pkg::ST_STD: begin
        ws_step = 1'b1;
        if (ws_expired) begin
          // early first-half sample
          // late wait seen now: first half taken after standard states only
          if (is_split(r.rq) && !r.second && !ext_wait_n) begin
            next_r.rdata[15:0] = data_in;
          end
          if (r.rq.write) begin
            next_r.wr_n = 1'b1;
          end
          if (!ext_wait_n) begin
            next_r.st = ebwe_pkg::ST_HOLD;
          end else begin
            next_r.st = ebwe_pkg::ST_DONE;
          end
        end else if (!ext_wait_n) begin
          next_r.st = ebwe_pkg::ST_HOLD;
        end
      end
      ebwe_pkg::ST_HOLD: begin
        if (r.rq.write && r.late) begin
          next_r.wr_n = 1'b1;
        end
        // back through STD so the closing cycle is the same on every path
        if (ext_wait_n) begin
          next_r.st = ebwe_pkg::ST_STD;
        end
      end
      ebwe_pkg::ST_DONE: begin
        if (is_split(r.rq) && !r.second) begin
          // first half unless already taken early
          if (!r.late) begin
            next_r.rdata[15:0] = data_in;
          end
          next_r.second = 1'b1;
          next_r.late   = 1'b0;
          next_r.addr   = r.addr + 24'h2;
          ws_load       = 1'b1;
          next_r.st     = ebwe_pkg::ST_STD;
        end else begin
          if (!r.rq.write) begin
            if (is_split(r.rq)) begin
              next_r.rdata[31:16] = data_in;
            end else if (r.rq.size == ebwe_pkg::SIZE_BYTE) begin
              next_r.rdata = {24'h000000, data_in[7:0]};
            end else begin
              next_r.rdata = {16'h0000, data_in};
            end
          end
          next_r.cs_n  = 1'b1;
          next_r.rd_n  = 1'b1;
          next_r.wr_n  = 1'b1;
          next_r.oe_n  = 1'b1;
          next_r.done  = 1'b1;
          next_r.ready = 1'b1;
          next_r.st    = ebwe_pkg::ST_IDLE;
        end
      end
      default: begin
        next_r.st    = ebwe_pkg::ST_IDLE;
        next_r.ready = 1'b1;
      end
    endcase
    // the early half is taken on the stretch, so latch the late flag here
    if (r.st == ebwe_pkg::ST_STD && !ext_wait_n && !ws_expired) begin
      next_r.late = 1'b0;
    end else if (r.st == ebwe_pkg::ST_STD && ws_expired && !ext_wait_n) begin
      next_r.late = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r        <= '0;
      r.st     <= ebwe_pkg::ST_IDLE;
      r.ready  <= 1'b1;
      r.oe_n   <= 1'b1;
      r.cs_n   <= 1'b1;
      r.rd_n   <= 1'b1;
      r.wr_n   <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  assign req_ready      = r.ready;
  assign done           = r.done;
  assign rdata          = r.rdata;
  assign data_out       = r.dout;
  assign data_oe_n      = r.oe_n;
  assign addr_out       = r.addr;
  assign chip_select_n  = r.cs_n;
  assign read_strobe_n  = r.rd_n;
  assign write_strobe_n = r.wr_n;
endmodule : ebwe_top

// File: design/ebwe_wait_counter.sv
// ebwe_wait_counter: counts programmed standard wait states of one half.
// assumes load and step are never high together with an idle phase.
`timescale 1ns/1ps
module ebwe_wait_counter (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // control
  input  wire logic                     load,
  input  wire logic [ebwe_pkg::WS_W-1:0] load_value,
  input  wire logic                     step,
  // status
  output logic                          expired
);
  logic [ebwe_pkg::WS_W-1:0] count;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= ebwe_pkg::WS_RST;
    end else if (load) begin
      count <= load_value;
    end else if (step && count != ebwe_pkg::WS_RST) begin
      count <= count - 3'h1;
    end
  end

  assign expired = (count == ebwe_pkg::WS_RST);
endmodule : ebwe_wait_counter

// File: dv/ebwe_chk.sv
// ebwe_chk: port assertions for ebwe_top.
// assumes one clock domain with an async active-high reset.
`timescale 1ns/1ps
// ====
module ebwe_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic done,
  // pins
  input wire logic ext_wait_n,
  input wire logic data_oe_n,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_idle_quiet: assert property (
    req_ready |-> chip_select_n && write_strobe_n) else $error("idle pins");
  a_take_select: assert property (
    req_valid && req_ready |=> !chip_select_n) else $error("no select");
  a_select_cause: assert property (
    $fell(chip_select_n) |-> $past(req_valid && req_ready)) else $error("cs");
  a_done_pulse: assert property (
    done |=> !done && req_ready) else $error("done pulse");
  a_min_len: assert property (
    done |-> !$past(chip_select_n) && !$past(chip_select_n, 2))
    else $error("short access");
  a_strobe_cs: assert property (
    !(read_strobe_n && write_strobe_n) |-> !chip_select_n) else $error("strb");
  a_write_lane: assert property (
    !write_strobe_n |-> !data_oe_n && read_strobe_n) else $error("lane");
  a_wait_hold: assert property (
    (!chip_select_n && !ext_wait_n) [*2] |=> !done) else $error("wait");
  cover property (!read_strobe_n && !ext_wait_n);
  cover property (!write_strobe_n ##[1:20] done);
  cover property (done ##1 req_valid);
endmodule : ebwe_chk

bind ebwe_top ebwe_chk ebwe_chk_inst (.clk(clk), .rst(rst),
  .req_valid(req_valid), .req_ready(req_ready), .done(done),
  .ext_wait_n(ext_wait_n), .data_oe_n(data_oe_n),
  .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n));

// File: dv/ebwe_mem_model.sv
// ebwe_mem_model: external memory with a programmable wait profile.
// assumes the bench keeps standard wait states legal for its wait use.
`timescale 1ns/1ps
// ====
module ebwe_mem_model (
  // clock
  input  wire logic        clk,
  // bus pins
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic [23:0] addr,
  output logic             wait_n,
  output logic [15:0]      data,
  // wait profile
  input  wire logic [2:0]  dly,
  input  wire logic [2:0]  len
);
  logic [3:0]  cnt;
  logic [15:0] last;
  always_ff @(posedge clk) begin
    cnt <= cs_n ? 4'h0 : cnt + 4'h1;
    last <= data;
  end
  assign wait_n = cs_n || cnt < {1'b0, dly} || cnt >= {1'b0, dly} + len;
  // released bus toggles so stale data matches only every second cycle
  assign data = (!cs_n && !rd_n) ? addr[15:0] ^ 16'h5a3c : ~last;
endmodule : ebwe_mem_model

// File: dv/testbench.sv
// testbench: random and corner accesses against the memory model.
// assumes the hand-over timing of ebwe_top.
`timescale 1ns/1ps
// ====
module testbench;
  logic clk, rst, req_valid, req_ready, done, ext_wait_n, data_oe_n;
  logic chip_select_n, read_strobe_n, write_strobe_n;
  ebwe_pkg::ebwe_req_t req;
  logic [31:0] rdata;
  logic [15:0] data_in, data_out;
  logic [23:0] addr_out;
  logic [2:0]  dly, len, ws;
  logic [1:0]  sz;
  logic        w;
  int seed, mismatches, n_compared, n_cs, n_we;
  ebwe_top ebwe_top_inst (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .done(done), .rdata(rdata),
    .ext_wait_n(ext_wait_n), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .addr_out(addr_out),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n));
  ebwe_mem_model ebwe_mem_model_inst (.clk(clk), .cs_n(chip_select_n),
    .rd_n(read_strobe_n), .addr(addr_out), .wait_n(ext_wait_n),
    .data(data_in), .dly(dly), .len(len));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  function automatic logic [15:0] mem(logic [23:0] a);
    return a[15:0] ^ 16'h5a3c;
  endfunction : mem
  always @(negedge clk) begin
    n_cs += !chip_select_n;
    n_we += !write_strobe_n;
    if (!write_strobe_n)
      check("wdata", data_out, req.wdata[15:0]);
  end
  task automatic access(logic w, logic [1:0] sz, logic [2:0] ws,
                        logic [2:0] d, logic [2:0] l);
    logic [23:0] a;
    int n;
    a = 24'($random(seed)) & 24'hfffffe;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{w, sz, ws, a, 32'($random(seed))};
    dly <= d;
    len <= l;
    @(posedge clk);
    req_valid <= 1'b0;
    n_cs = 0;
    n_we = 0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      print_verdict();
    end
    if (!w && sz == 2'h2)
      check("word", rdata, {mem(a + 24'h2), mem(a)});
    else if (!w)
      check("rdata", rdata, {16'h0, mem(a)} &
            (sz == 2'h0 ? 32'hff : 32'hffff));
    if (sz != 2'h2 && (l == 0 || d < ws))
      check("length", 32'(n), 32'(ws + 3 + l));
    if (w && l != 0 && d == ws)
      check("cs_ext", 32'(n_cs > n_we), 32'h1);
  endtask : access
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    seed = 78956;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    dly = 3'h0;
    len = 3'h0;
    {mismatches, n_compared} = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    access(0, 0, 0, 0, 0);
    access(0, 2, 2, 0, 3);
    access(0, 1, 2, 1, 2);
    access(0, 2, 2, 2, 3);
    access(1, 1, 2, 2, 3);
    for (int i = 0; i < 40; i++) begin
      w = 1'($random(seed));
      sz = 2'(($random(seed) & 'hff) % 3);
      ws = ((w || sz == 2'h2) ? 3'h2 : 3'h1) + 3'($random(seed) & 3);
      access(w, sz, ws, 3'(($random(seed) & 'hff) % (ws + 1)),
             3'($random(seed) & 3));
    end
    print_verdict();
  end
endmodule : testbench
